// file: usrm_pkg.sv
// package: register map, field layout and constants of the upstream rx mask
// Overview of operation
// - mask exists only in target nodes; a controller node ignores it.
// - eight-bit mask selects which upstream slots 8 to 15 are captured.
// - bit 7 governs slot 15 down to bit 0 governing slot 8.
// - bit 0 skips its slot, bit 1 receives its slot.
// - forwarded upstream slots follow all captured downstream slots.
// - old mask stays active until the controller commits a new structure.
package usrm_pkg;
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;
   localparam int          MASK_W        = 8;
   localparam int          SLOT_W        = 5;
   localparam int          WORD_W        = 32;
   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_MASK      = 8'h61;
   localparam logic [7:0]  IDX_ACTIVE    = 8'h70;
   localparam logic [7:0]  IDX_STATUS    = 8'h71;
   localparam logic [7:0]  IDX_DN_COUNT  = 8'h72;
   localparam logic [7:0]  MASK_RESET    = 8'h00;
   localparam logic [4:0]  FIRST_SLOT    = 5'h08;
   localparam logic [4:0]  LAST_SLOT     = 5'h0f;
   localparam logic [5:0]  DN_CNT_RESET  = 6'h00;
   localparam int          DN_CNT_W      = 6;
   localparam int          ST_ROLE_BIT   = 0;
   localparam int          ST_PEND_BIT   = 1;
   localparam int          BUF_DEPTH     = 2;
   typedef enum logic [1:0] {USRM_IDLE, USRM_DOWN, USRM_UP} usrm_phase_t;
endpackage

// file: usrm_upstream_rx_mask.sv
// upstream slot 8..15 receive mask with commit and serial port forwarding
`timescale 1ns/100ps
module usrm_upstream_rx_mask (
   input  wire logic                  clk,
   input  wire logic                  resetn,
   input  wire logic [31:0]           wb_adr_i,
   input  wire logic [31:0]           wb_dat_i,
   output      logic [31:0]           wb_dat_o,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic                  wb_we_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   output      logic                  wb_ack_o,
   output      logic                  wb_err_o,
   input  wire logic                  node_is_target,
   input  wire logic                  commit_new_bus_structure,
   input  wire logic                  bus_slot_valid,
   input  wire logic                  bus_slot_is_up,
   input  wire logic [4:0]            bus_slot_num,
   input  wire logic [31:0]           bus_slot_data,
   input  wire logic                  dn_slot_captured,
   input  wire logic                  superframe_start,
   output      logic                  bus_slot_ready,
   output      logic                  sp_valid,
   output      logic [31:0]           sp_data,
   output      logic [4:0]            sp_slot,
   input  wire logic                  sp_ready
);

   // register state: both mask copies, bus answer and the slot buffer
   logic [7:0]                 pend_mask_reg;
   logic [7:0]                 act_mask_reg;
   logic                       pend_dirty_reg;
   logic [5:0]                 dn_cnt_reg;
   logic                       ack_reg;
   logic                       err_reg;
   logic [31:0]                rdata_reg;
   usrm_pkg::usrm_phase_t      phase_reg;
   logic [31:0]                buf_data_reg [usrm_pkg::BUF_DEPTH];
   logic [4:0]                 buf_slot_reg [usrm_pkg::BUF_DEPTH];
   logic [1:0]                 buf_cnt_reg;
   logic                       wr_ptr_reg;
   logic                       rd_ptr_reg;
   // decode and handshake nets
   logic                       req;
   logic                       hit_mask;
   logic                       hit_known;
   logic                       take_slot;
   logic                       push;
   logic                       pop;
   logic [7:0]                 idx;

   // map slot number 8..15 onto mask bit 0..7, zero outside the range;
   // the range test keeps slots 0..7 and 16..31 from aliasing onto bits
   function automatic logic slot_enabled(input logic [7:0] m,
                                         input logic [4:0] s);
      logic [4:0] b;
      b = 5'(s - usrm_pkg::FIRST_SLOT);
      if (s < usrm_pkg::FIRST_SLOT || s > usrm_pkg::LAST_SLOT) begin
         slot_enabled = 1'b0;
      end else begin
         slot_enabled = m[b[2:0]];
      end
   endfunction

   // true for any word index that the register map answers with ack;
   // every other index gets err and leaves both mask copies alone, so a stray
   // address can never disturb the pending or active mask
   function automatic logic idx_known(input logic [7:0] i);
      case (i)
         usrm_pkg::IDX_MASK,
         usrm_pkg::IDX_ACTIVE,
         usrm_pkg::IDX_STATUS,
         usrm_pkg::IDX_DN_COUNT: idx_known = 1'b1;
         default:                idx_known = 1'b0;
      endcase
   endfunction

   // bus decode: word index from byte address; a request counts once,
   // on the edge before its answer, never again while ack or err stands
   assign idx       = wb_adr_i[9:2];
   assign req       = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
   assign hit_mask  = (idx == usrm_pkg::IDX_MASK);
   assign hit_known = idx_known(idx);
   assign wb_ack_o  = ack_reg;
   assign wb_err_o  = err_reg;
   assign wb_dat_o  = rdata_reg;

   // one-cycle ack or err per request, dropped the cycle after;
   // registered so the answer never depends on the address in flight
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         ack_reg <= req && hit_known;
         err_reg <= req && !hit_known;
      end
   end

   // read data mux registered with the ack;
   // only reads load it, so the word stays put until the next read
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_reg <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         case (idx)
            usrm_pkg::IDX_MASK:     rdata_reg <= {24'h0, pend_mask_reg};
            usrm_pkg::IDX_ACTIVE:   rdata_reg <= {24'h0, act_mask_reg};
            usrm_pkg::IDX_STATUS:   rdata_reg <= {30'h0, pend_dirty_reg,
                                                  node_is_target};
            usrm_pkg::IDX_DN_COUNT: rdata_reg <= {26'h0, dn_cnt_reg};
            default:                rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // pending copy written by software; dirty until the next commit.
   // a write that meets a commit in one cycle keeps dirty set, because
   // the commit has then loaded the older pending value
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pend_mask_reg  <= usrm_pkg::MASK_RESET;
         pend_dirty_reg <= 1'b0;
      end else begin
         if (req && wb_we_i && hit_mask && wb_sel_i[0]) begin
            pend_mask_reg  <= wb_dat_i[7:0];
            pend_dirty_reg <= 1'b1;
         end else if (commit_new_bus_structure) begin
            pend_dirty_reg <= 1'b0;
         end
      end
   end

   // active copy changes only on the controller's commit; a new mask
   // never reaches the capture logic half way through a structure
   always_ff @(posedge clk) begin
      if (!resetn) begin
         act_mask_reg <= usrm_pkg::MASK_RESET;
      end else if (commit_new_bus_structure) begin
         act_mask_reg <= pend_mask_reg;
      end
   end

   // superframe phase: downstream slots first, then upstream;
   // a new superframe restarts the downstream count
   always_ff @(posedge clk) begin
      if (!resetn) begin
         phase_reg  <= usrm_pkg::USRM_IDLE;
         dn_cnt_reg <= usrm_pkg::DN_CNT_RESET;
      end else if (superframe_start) begin
         phase_reg  <= usrm_pkg::USRM_DOWN;
         dn_cnt_reg <= usrm_pkg::DN_CNT_RESET;
      end else begin
         case (phase_reg)
            usrm_pkg::USRM_DOWN: begin
               if (dn_slot_captured) begin
                  dn_cnt_reg <= 6'(dn_cnt_reg + 6'h01);
               end
               if (bus_slot_valid && bus_slot_is_up && bus_slot_ready) begin
                  phase_reg <= usrm_pkg::USRM_UP;
               end
            end
            usrm_pkg::USRM_UP:   phase_reg <= usrm_pkg::USRM_UP;
            usrm_pkg::USRM_IDLE: phase_reg <= usrm_pkg::USRM_IDLE;
            default:             phase_reg <= usrm_pkg::USRM_IDLE;
         endcase
      end
   end

   // capture only enabled upstream slots in a target node; disabled
   // slots are dropped but still stall the bus side while the buffer is full, and nothing is
   // taken before the first superframe has opened the downstream phase
   assign take_slot = bus_slot_valid && bus_slot_is_up &&
                      node_is_target &&
                      phase_reg != usrm_pkg::USRM_IDLE &&
                      slot_enabled(act_mask_reg, bus_slot_num);
   assign bus_slot_ready = (buf_cnt_reg != 2'(usrm_pkg::BUF_DEPTH));
   assign push = take_slot && bus_slot_ready;
   assign pop  = sp_valid && sp_ready;
   assign sp_valid = (buf_cnt_reg != 2'h0);
   assign sp_data  = buf_data_reg[rd_ptr_reg];
   assign sp_slot  = buf_slot_reg[rd_ptr_reg];

   // two-entry buffer toward the serial audio port; two words let the
   // port stall for a cycle while the bus side keeps going, and a push
   // and a pop in one cycle leave the count unchanged
   always_ff @(posedge clk) begin
      if (!resetn) begin
         buf_cnt_reg <= 2'h0;
         wr_ptr_reg  <= 1'b0;
         rd_ptr_reg  <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= !wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= !rd_ptr_reg;
         end
         if (push && !pop) begin
            buf_cnt_reg <= 2'(buf_cnt_reg + 2'h1);
         end else if (pop && !push) begin
            buf_cnt_reg <= 2'(buf_cnt_reg - 2'h1);
         end
      end
   end

   // buffer storage; only the entry under the write pointer moves,
   // so the word on offer to the port stays stable
   always_ff @(posedge clk) begin
      if (!resetn) begin
         buf_data_reg[0] <= 32'h0000_0000;
         buf_data_reg[1] <= 32'h0000_0000;
         buf_slot_reg[0] <= 5'h00;
         buf_slot_reg[1] <= 5'h00;
      end else if (push) begin
         buf_data_reg[wr_ptr_reg] <= bus_slot_data;
         buf_slot_reg[wr_ptr_reg] <= bus_slot_num;
      end
   end

endmodule

// file: usrm_monitor.sv
// checker: bus timing and mask relations at the rx mask ports
`timescale 1ns/100ps
module usrm_monitor (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic [3:0]  wb_sel_i,
   input wire logic        wb_we_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        wb_err_o,
   input wire logic        node_is_target,
   input wire logic        commit_new_bus_structure,
   input wire logic        bus_slot_valid,
   input wire logic        bus_slot_is_up,
   input wire logic [4:0]  bus_slot_num,
   input wire logic        sp_valid,
   input wire logic [4:0]  sp_slot
);
   logic [7:0] pend_reg;
   logic [7:0] act_reg;
   logic [7:0] idx;
   logic       take;
   logic       rd_ack;
   logic       up_hit;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // taken request, read answer and an upstream slot in 8..15
   assign idx    = wb_adr_i[9:2];
   assign take   = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
   assign rd_ack = wb_ack_o & !wb_we_i;
   assign up_hit = bus_slot_valid & bus_slot_is_up &
                   bus_slot_num[4:3] == 2'b01;
   // shadow of the pending and active mask copies
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pend_reg <= 8'h00;
         act_reg  <= 8'h00;
      end else begin
         if (take & wb_we_i & wb_sel_i[0] & idx == usrm_pkg::IDX_MASK)
            pend_reg <= wb_dat_i[7:0];
         if (commit_new_bus_structure)
            act_reg <= pend_reg;
      end
   end
   AST_ACK_ONE: assert property (
      take |=> (wb_ack_o | wb_err_o) ##1 !wb_ack_o)
      else $error("no single answer after request");
   AST_PEND_RD: assert property (
      rd_ack && idx == usrm_pkg::IDX_MASK |->
      wb_dat_o == {24'h0, $past(pend_reg)}) else $error("pending read wrong");
   AST_ACT_RD: assert property (
      rd_ack && idx == usrm_pkg::IDX_ACTIVE |->
      wb_dat_o == {24'h0, $past(act_reg)}) else $error("active read wrong");
   AST_CTRL_OFF: assert property (
      !node_is_target && !sp_valid |=> !sp_valid)
      else $error("controller node captured a slot");
   AST_SLOT_RANGE: assert property (
      sp_valid |-> sp_slot[4:3] == 2'b01)
      else $error("forwarded slot outside range");
   AST_BIT_MAP: assert property (
      $rose(sp_valid) |->
      sp_slot == $past(bus_slot_num) && $past(act_reg[bus_slot_num[2:0]]))
      else $error("slot forwarded against its mask bit");
   AST_SKIP: assert property (
      up_hit && !act_reg[bus_slot_num[2:0]] && !sp_valid |=> !sp_valid)
      else $error("disabled slot stored");
   // main scenarios
   cover property (commit_new_bus_structure);
   cover property ($rose(sp_valid));
   cover property (wb_err_o);
endmodule
bind usrm_upstream_rx_mask usrm_monitor mon (.clk(clk), .resetn(resetn),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
   .node_is_target(node_is_target),
   .commit_new_bus_structure(commit_new_bus_structure),
   .bus_slot_valid(bus_slot_valid), .bus_slot_is_up(bus_slot_is_up),
   .bus_slot_num(bus_slot_num), .sp_valid(sp_valid), .sp_slot(sp_slot));

// file: usrm_port_sink.sv
// serial port sink that logs the forwarded slot numbers
`timescale 1ns/100ps
module usrm_port_sink (
   input  wire logic       clk,
   input  wire logic       stall,
   input  wire logic       sp_valid,
   input  wire logic [4:0] sp_slot,
   input  wire logic [31:0] sp_data,
   output      logic       sp_ready
);
   logic [4:0]  got_q[$];
   logic [31:0] got_d[$];
   assign sp_ready = !stall;
   // accept a word at each edge where one is offered and not stalled
   always @(posedge clk)
      if (sp_valid & !stall) begin
         got_q.push_back(sp_slot);
         got_d.push_back(sp_data);
      end
endmodule

// file: usrm_upstream_rx_mask_tb.sv
// testbench: mask access, commit and forwarding of upstream slots
`timescale 1ns/100ps
module usrm_upstream_rx_mask_tb;
   logic        clk = 0, resetn = 0, we = 0, cyc = 0, stb = 0, tgt = 1;
   logic        commit = 0, sv = 0, sf = 0, stall = 1, ack, err, re;
   logic        rdy, spv, spr, dn = 0, up = 1;
   logic [31:0] adr = 0, dat = 0, dout, rd, spd;
   logic [4:0]  snum = 0, sps;
   logic [4:0]  exp_s [5] = '{5'h08, 5'h0f, 5'h08, 5'h08, 5'h09};
   int          err_total = 0, checks_done = 0;
   always #20 clk = ~clk;
   usrm_upstream_rx_mask uut (.clk(clk), .resetn(resetn), .wb_adr_i(adr),
      .wb_dat_i(dat), .wb_dat_o(dout), .wb_sel_i(4'hf), .wb_we_i(we),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .wb_err_o(err),
      .node_is_target(tgt), .commit_new_bus_structure(commit),
      .bus_slot_valid(sv), .bus_slot_is_up(up), .bus_slot_num(snum),
      .bus_slot_data({27'h0, snum}), .dn_slot_captured(dn),
      .superframe_start(sf), .bus_slot_ready(rdy), .sp_valid(spv),
      .sp_data(spd), .sp_slot(sps), .sp_ready(spr));
   usrm_port_sink sink (.clk(clk), .stall(stall), .sp_valid(spv),
      .sp_slot(sps), .sp_data(spd), .sp_ready(spr));
   // one classic bus cycle; data and error taken at the ack edge
   task automatic acc(input logic w, input logic [7:0] i,
                      input logic [31:0] d);
      adr <= {22'h0, i, 2'b00};
      dat <= d;
      {cyc, stb, we} <= {2'b11, w};
      do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
      {rd, re} = {dout, err};
      {cyc, stb} <= 2'b00;
      @(posedge clk);
   endtask
   // offer one slot word and hold it until the buffer is ready
   task automatic slot(input logic [4:0] n);
      {sv, snum} <= {1'b1, n};
      do @(posedge clk); while (rdy !== 1'b1);
      sv <= 1'b0;
      @(posedge clk);
   endtask
   // one-cycle pulse on commit, superframe start or downstream capture
   task automatic pulse(input logic [2:0] p);
      {commit, sf, dn} <= p;
      @(posedge clk);
      {commit, sf, dn} <= 3'b000;
      @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      acc(1'b0, usrm_pkg::IDX_MASK, 32'h0);
      chk(rd, 32'h0);
      acc(1'b1, usrm_pkg::IDX_MASK, 32'h81);
      acc(1'b0, usrm_pkg::IDX_MASK, 32'h0);
      chk(rd, 32'h81);
      acc(1'b0, usrm_pkg::IDX_STATUS, 32'h0);
      chk(rd, 32'h3);
      acc(1'b0, usrm_pkg::IDX_ACTIVE, 32'h0);
      chk(rd, 32'h0);
      pulse(3'b100);
      acc(1'b1, usrm_pkg::IDX_ACTIVE, 32'hff);
      acc(1'b0, usrm_pkg::IDX_ACTIVE, 32'h0);
      chk(rd, 32'h81);
      slot(5'h0f);
      pulse(3'b010);
      pulse(3'b001);
      pulse(3'b001);
      up <= 1'b0;
      slot(5'h08);
      up <= 1'b1;
      acc(1'b0, usrm_pkg::IDX_DN_COUNT, 32'h0);
      chk(rd, 32'h2);
      fork
         begin
            repeat (30) @(posedge clk);
            chk({31'h0, rdy}, 32'h0);
            stall <= 1'b0;
         end
      join_none
      for (int k = 7; k <= 16; k++)
         slot(5'(k));
      slot(5'h08);
      slot(5'h09);
      acc(1'b1, usrm_pkg::IDX_MASK, 32'h02);
      slot(5'h09);
      slot(5'h08);
      pulse(3'b100);
      acc(1'b0, usrm_pkg::IDX_STATUS, 32'h0);
      chk(rd, 32'h1);
      slot(5'h09);
      slot(5'h08);
      tgt <= 1'b0;
      slot(5'h09);
      acc(1'b0, 8'h10, 32'h0);
      chk({31'h0, re}, 32'h1);
      chk(sink.got_q.size(), 5);
      foreach (exp_s[k]) chk({27'h0, sink.got_q[k]}, {27'h0, exp_s[k]});
      foreach (exp_s[k]) chk(sink.got_d[k], {27'h0, exp_s[k]});
      conclude();
   end
   // watchdog cuts a hang short
   initial begin
      #80000;
      err_total++;
      conclude();
   end
endmodule
